// ---- eeprom_dev_model.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "eeprom_host_params.svh"
module eeprom_dev_model #(
  parameter int IDLE_CYC = 1000,
  parameter int BUSY_CYC = 200,
  parameter int SLOW_CYC = 2000
) (
  input  wire logic        clk,
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic [16:0] addr,
  input  wire logic [7:0]  data_out,
  input  wire logic        data_oe_n,
  input  wire logic        hold_off_n,
  input  wire logic        slow,
  output logic      [7:0]  data_in,
  output logic             ready_busy_in
);
  logic [7:0]  mem [0:131071];
  logic [16:0] pa [$];
  logic [7:0]  pd [$];
  logic [16:0] seq_a [0:5] = '{`CMD_ADDR_A, `CMD_ADDR_B, `CMD_ADDR_A, `CMD_ADDR_A,
                               `CMD_ADDR_B, `CMD_ADDR_A};
  logic [7:0]  seq_d [0:5] = '{8'hAA, 8'h55, 8'h80, 8'hAA, 8'h55, 8'h20};
  logic [7:0]  last = 8'h00;
  logic [7:0]  tog = 8'h00;
  logic        wr_low = 0, busy = 0, prog = 0, prot = 0, armed = 0;
  int          idle = 0, cnt = 0;
  // Upper two address bits ignored so every command alias matches
  function automatic logic seq_ok(input int n, input logic [7:0] d3);
    logic ok;
    ok = (pa.size() == n);
    for (int i = 0; i < n; i++) begin
      if (ok && (pa[i][14:0] != seq_a[i][14:0] || pd[i] != (i == 2 ? d3 : seq_d[i]))) ok = 0;
    end
    return ok;
  endfunction
  initial begin
    foreach (mem[i]) mem[i] = 8'hFF;
  end
  // Negedge sampling avoids racing the host's registered strobes
  always @(negedge clk) begin
    if (hold_off_n !== 1'b1) begin
      pa.delete();
      pd.delete();
      {wr_low, busy, prog, armed} = 4'h0;
    end else begin
      if (!ce_n && !we_n && !prog) begin
        wr_low = 1;
      end else if (wr_low) begin
        wr_low = 0;
        idle = 0;
        busy = 1;
        last = data_oe_n ? tog : data_out;
        pa.push_back(addr);
        pd.push_back(last);
        if (seq_ok(3, `CMD_DATA_LOCK) || seq_ok(6, `CMD_DATA_ERASE)) begin
          prot = (pa.size() == 3);
          armed = prot;
          pa.delete();
          pd.delete();
        end
      end else if (we_n && busy && !prog) begin
        idle = idle + 1;
        if (idle >= IDLE_CYC) begin
          prog = 1'b1;
          cnt = slow ? SLOW_CYC : BUSY_CYC;
        end
      end
      if (prog) begin
        cnt = cnt - 1;
      end
      if (prog && cnt == 0) begin
        if (!prot || armed) foreach (pa[i]) mem[pa[i]] = pd[i];
        pa.delete();
        pd.delete();
        {busy, prog, armed} = 3'h0;
      end
    end
    tog = tog + 8'h5B;
  end
  assign data_in = (!ce_n && !oe_n && hold_off_n === 1'b1) ?
                   (busy ? {~last[7], tog[6:0]} : mem[addr]) : tog;
  assign ready_busy_in = !busy;
endmodule // eeprom_dev_model
`default_nettype wire

// ---- eeprom_host.sv ----
// Operation
// - Each following byte of a page is loaded within 30 us of the previous.
// - Hold-off is held high through every read and programming access.
// - Hold-off stays high 10 ms after the last byte loaded; the code only flags this on reset_safe, and srst drops hold-off at any time.
// - Hold-off follows this controller's reset.
// - In protected mode every page starts with the three-byte command prefix.
// - Six-byte sequence cancels protection so plain writes are accepted.
`timescale 1ns/100ps
`default_nettype none
`include "eeprom_host_params.svh"
module eeprom_host
  import eeprom_host_pkg::*;
#(
  parameter int WC_CYC       = `WC_CYC,
  parameter int RES_HOLD_CYC = `RES_HOLD_CYC
) (
  input  wire logic               clk,
  input  wire logic               srst,
  input  wire logic               cmd_valid,
  output logic                    cmd_ready,
  input  wire op_e                cmd_op,
  input  wire logic [`ADDR_W-1:0] cmd_addr,
  input  wire logic [`DATA_W-1:0] cmd_data,
  input  wire logic               cmd_last,
  output logic                    rsp_valid,
  output logic      [`DATA_W-1:0] rsp_data,
  output logic                    rsp_timeout,
  output logic                    protected_mode,
  output logic                    reset_safe,
  output logic                    ce_n,
  output logic                    oe_n,
  output logic                    we_n,
  output logic      [`ADDR_W-1:0] addr,
  output logic      [`DATA_W-1:0] data_out,
  output logic                    data_oe_n,
  input  wire logic [`DATA_W-1:0] data_in,
  input  wire logic               ready_busy_in,
  output logic                    hold_off_n
);

  state_e                  state;
  state_e                  next_state;
  logic [`CNT_W-1:0]       cnt;
  logic [`CNT_W-1:0]       next_cnt;
  logic [`SUB_W-1:0]       sub;
  logic [`SUB_W-1:0]       next_sub;
  logic [`GUARD_W-1:0]     guard;
  logic [`GUARD_W-1:0]     next_guard;
  logic [`SEQ_W-1:0]       seq_idx;
  logic [`SEQ_W-1:0]       next_seq_idx;
  logic [`SEQ_W-1:0]       seq_end;
  logic [`SEQ_W-1:0]       next_seq_end;
  logic                    want_data;
  logic                    next_want_data;
  logic                    have_data;
  logic                    next_have_data;
  logic                    close_req;
  logic                    next_close_req;
  logic [`ADDR_W-1:0]      wr_addr;
  logic [`ADDR_W-1:0]      next_wr_addr;
  logic [`DATA_W-1:0]      wr_data;
  logic [`DATA_W-1:0]      next_wr_data;
  logic                    last_bit7;
  logic                    next_last_bit7;
  logic                    next_protected_mode;
  logic                    next_rsp_valid;
  logic [`DATA_W-1:0]      next_rsp_data;
  logic                    next_rsp_timeout;
  logic                    next_ce_n;
  logic                    next_oe_n;
  logic                    next_we_n;
  logic [`ADDR_W-1:0]      next_addr;
  logic [`DATA_W-1:0]      next_data_out;
  logic                    next_data_oe_n;
  logic [`DATA_W:0]        pins_sync;
  logic [`DATA_W-1:0]      din;
  logic                    ready_sync;
  logic                    same_page;
  logic                    gap_open;

  pin_sync3 #(
    .W    (`DATA_W + 1)
  ) u_sync (
    .clk  (clk),
    .srst (srst),
    .pin  ({ready_busy_in, data_in}),
    .q    (pins_sync)
  );

  assign din        = pins_sync[`DATA_W-1:0];
  assign ready_sync = pins_sync[`DATA_W];

  // Command table: lock prefix at 0..2, cancel sequence at 3..8
  function automatic logic [`ADDR_W+`DATA_W-1:0] seq_entry(input logic [`SEQ_W-1:0] i);
    case (i)
      4'h0:    seq_entry = {`CMD_ADDR_A, `CMD_DATA_1};
      4'h1:    seq_entry = {`CMD_ADDR_B, `CMD_DATA_2};
      4'h2:    seq_entry = {`CMD_ADDR_A, `CMD_DATA_LOCK};
      4'h3:    seq_entry = {`CMD_ADDR_A, `CMD_DATA_1};
      4'h4:    seq_entry = {`CMD_ADDR_B, `CMD_DATA_2};
      4'h5:    seq_entry = {`CMD_ADDR_A, `CMD_DATA_ERASE};
      4'h6:    seq_entry = {`CMD_ADDR_A, `CMD_DATA_1};
      4'h7:    seq_entry = {`CMD_ADDR_B, `CMD_DATA_2};
      4'h8:    seq_entry = {`CMD_ADDR_A, `CMD_DATA_UNLOCK};
      default: seq_entry = {`CMD_ADDR_A, `CMD_DATA_1};
    endcase
  endfunction

  assign same_page = cmd_addr[`ADDR_W-1:`PAGE_LSB] == wr_addr[`ADDR_W-1:`PAGE_LSB];
  assign gap_open  = cnt < `CNT_W'(`GAP_LIMIT);

  // Busy device gets no write strobes until polling clears or times out
  always_comb begin
    case (state)
      S_IDLE:  cmd_ready = 1'b1;
      S_GAP:   cmd_ready = !close_req && gap_open && cmd_op == OP_WRITE && same_page;
      default: cmd_ready = 1'b0;
    endcase
  end

  always_comb begin
    next_state          = state;
    next_cnt            = cnt;
    next_sub            = sub;
    next_guard          = (guard == `GUARD_W'(RES_HOLD_CYC)) ? guard : guard + 1'b1;
    next_seq_idx        = seq_idx;
    next_seq_end        = seq_end;
    next_want_data      = want_data;
    next_have_data      = have_data;
    next_close_req      = close_req;
    next_wr_addr        = wr_addr;
    next_wr_data        = wr_data;
    next_last_bit7      = last_bit7;
    next_protected_mode = protected_mode;
    next_rsp_valid      = 1'b0;
    next_rsp_data       = rsp_data;
    next_rsp_timeout    = rsp_timeout;
    next_ce_n           = 1'b1;
    next_oe_n           = 1'b1;
    next_we_n           = 1'b1;
    next_addr           = addr;
    next_data_out       = data_out;
    next_data_oe_n      = 1'b1;
    case (state)
      S_BOOT: begin
        next_cnt = cnt + 1'b1;
        if (cnt == `CNT_W'(`RP_CYC - 1)) begin
          next_cnt   = '0;
          next_state = S_IDLE;
        end
      end
      S_IDLE: begin
        if (cmd_valid) begin
          next_wr_addr   = cmd_addr;
          next_wr_data   = cmd_data;
          next_close_req = cmd_last;
          next_have_data = 1'b0;
          next_want_data = 1'b0;
          next_state     = S_NEXT;
          case (cmd_op)
            OP_READ: begin
              next_addr  = cmd_addr;
              next_sub   = '0;
              next_state = S_READ;
            end
            OP_WRITE: begin
              next_want_data = 1'b1;
              next_seq_idx   = `SEQ_W'(`SEQ_LOCK_FIRST);
              next_seq_end   = protected_mode ? `SEQ_W'(`SEQ_LOCK_END)
                                              : `SEQ_W'(`SEQ_LOCK_FIRST);
            end
            OP_LOCK: begin
              next_seq_idx        = `SEQ_W'(`SEQ_LOCK_FIRST);
              next_seq_end        = `SEQ_W'(`SEQ_LOCK_END);
              next_protected_mode = 1'b1;
              next_close_req      = 1'b1;
            end
            default: begin
              // Data-free sequence, so nothing lands in the array
              next_seq_idx        = `SEQ_W'(`SEQ_UNLOCK_FIRST);
              next_seq_end        = `SEQ_W'(`SEQ_UNLOCK_END);
              next_protected_mode = 1'b0;
              next_close_req      = 1'b1;
            end
          endcase
        end
      end
      S_NEXT: begin
        next_state = S_SETUP;
        if (seq_idx != seq_end) begin
          {next_addr, next_data_out} = seq_entry(seq_idx);
          next_seq_idx               = seq_idx + 1'b1;
        end else if (want_data) begin
          next_addr      = wr_addr;
          next_data_out  = wr_data;
          next_want_data = 1'b0;
          next_have_data = 1'b1;
          next_last_bit7 = wr_data[`DATA_W-1];
        end else begin
          next_cnt   = '0;
          next_state = S_GAP;
        end
        next_data_oe_n = (next_state == S_GAP);
      end
      S_SETUP: begin
        // Address and data settle a full cycle before the strobes fall
        next_data_oe_n = 1'b0;
        next_ce_n      = 1'b0;
        next_we_n      = 1'b0;
        next_sub       = '0;
        next_state     = S_STROBE;
      end
      S_STROBE: begin
        next_data_oe_n = 1'b0;
        next_sub       = sub + 1'b1;
        next_guard     = '0;
        if (sub == `SUB_W'(`WP_CYC - 1)) begin
          next_state = S_HOLD;
        end else begin
          next_ce_n = 1'b0;
          next_we_n = 1'b0;
        end
      end
      S_HOLD: begin
        next_data_oe_n = 1'b0;
        next_state     = S_NEXT;
      end
      S_GAP: begin
        next_cnt = cnt + 1'b1;
        if (cmd_ready && cmd_valid) begin
          next_wr_addr   = cmd_addr;
          next_wr_data   = cmd_data;
          next_want_data = 1'b1;
          next_close_req = cmd_last;
          next_state     = S_NEXT;
        end else if (close_req || !gap_open || cmd_valid) begin
          next_cnt   = '0;
          next_state = S_WAITBL;
        end
      end
      S_WAITBL: begin
        next_cnt = cnt + 1'b1;
        if (cnt == `CNT_W'(`BL_CYC - 1)) begin
          // Poll budget runs from here, so the whole wait stays inside WC_CYC
          next_cnt   = '0;
          next_sub   = '0;
          next_state = S_POLL;
        end
      end
      S_POLL: begin
        next_ce_n = 1'b0;
        next_oe_n = 1'b0;
        next_cnt  = cnt + 1'b1;
        next_sub  = sub + 1'b1;
        if (sub == `SUB_W'(`READ_CYC - 1)) begin
          next_sub = '0;
          if (ready_sync && (!have_data || din[`DATA_W-1] == last_bit7)) begin
            next_rsp_timeout = 1'b0;
            next_state       = S_DONE;
          end
        end
        if (cnt >= `CNT_W'(WC_CYC - `BL_CYC)) begin
          next_rsp_timeout = 1'b1;
          next_state       = S_DONE;
        end
        if (next_state == S_DONE) begin
          next_ce_n = 1'b1;
          next_oe_n = 1'b1;
        end
      end
      S_READ: begin
        next_ce_n = 1'b0;
        next_oe_n = 1'b0;
        next_sub  = sub + 1'b1;
        if (sub == `SUB_W'(`READ_CYC - 1)) begin
          next_ce_n        = 1'b1;
          next_oe_n        = 1'b1;
          next_rsp_data    = din;
          next_rsp_timeout = 1'b0;
          next_state       = S_DONE;
        end
      end
      S_DONE: begin
        next_rsp_valid = 1'b1;
        next_state     = S_IDLE;
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state          <= S_BOOT;
      cnt            <= '0;
      sub            <= '0;
      guard          <= '0;
      seq_idx        <= '0;
      seq_end        <= '0;
      want_data      <= 1'b0;
      have_data      <= 1'b0;
      close_req      <= 1'b0;
      wr_addr        <= '0;
      wr_data        <= '0;
      last_bit7      <= 1'b0;
      protected_mode <= 1'b0;
      rsp_valid      <= 1'b0;
      rsp_data       <= '0;
      rsp_timeout    <= 1'b0;
      ce_n           <= 1'b1;
      oe_n           <= 1'b1;
      we_n           <= 1'b1;
      addr           <= '0;
      data_out       <= '0;
      data_oe_n      <= 1'b1;
      hold_off_n     <= 1'b0;
    end else begin
      state          <= next_state;
      cnt            <= next_cnt;
      sub            <= next_sub;
      guard          <= next_guard;
      seq_idx        <= next_seq_idx;
      seq_end        <= next_seq_end;
      want_data      <= next_want_data;
      have_data      <= next_have_data;
      close_req      <= next_close_req;
      wr_addr        <= next_wr_addr;
      wr_data        <= next_wr_data;
      last_bit7      <= next_last_bit7;
      protected_mode <= next_protected_mode;
      rsp_valid      <= next_rsp_valid;
      rsp_data       <= next_rsp_data;
      rsp_timeout    <= next_rsp_timeout;
      ce_n           <= next_ce_n;
      oe_n           <= next_oe_n;
      we_n           <= next_we_n;
      addr           <= next_addr;
      data_out       <= next_data_out;
      data_oe_n      <= next_data_oe_n;
      hold_off_n     <= 1'b1;
    end
  end

  // Only the system reset may pull hold-off; this tells it when that is harmless
  assign reset_safe = (state == S_IDLE) && (guard == `GUARD_W'(RES_HOLD_CYC));

endmodule // eeprom_host
`default_nettype wire

// ---- eeprom_host_assertions.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "eeprom_host_params.svh"
module eeprom_host_assertions
  import eeprom_host_pkg::*;
#(
  parameter int WC_CYC       = `WC_CYC,
  parameter int RES_HOLD_CYC = `RES_HOLD_CYC
) (
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        cmd_valid,
  input wire logic        cmd_ready,
  input wire op_e         cmd_op,
  input wire logic [16:0] cmd_addr,
  input wire logic [7:0]  cmd_data,
  input wire logic        cmd_last,
  input wire logic        rsp_valid,
  input wire logic [7:0]  rsp_data,
  input wire logic        rsp_timeout,
  input wire logic        protected_mode,
  input wire logic        reset_safe,
  input wire logic        ce_n,
  input wire logic        oe_n,
  input wire logic        we_n,
  input wire logic [16:0] addr,
  input wire logic [7:0]  data_out,
  input wire logic        data_oe_n,
  input wire logic [7:0]  data_in,
  input wire logic        ready_busy_in,
  input wire logic        hold_off_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  wire logic take = cmd_valid && cmd_ready;
  property p_release; $fell(srst) |-> !hold_off_n ##1 hold_off_n; endproperty
  a_release: assert property (p_release) else $error("hold-off release");
  property p_hold; !ce_n |-> hold_off_n; endproperty
  a_hold: assert property (p_hold) else $error("hold-off low in access");
  property p_strobe; $fell(we_n) |-> (!we_n && !ce_n && oe_n)[*3] ##1 (we_n && ce_n); endproperty
  a_strobe: assert property (p_strobe) else $error("write strobe shape");
  property p_setup; !we_n |-> $stable(addr) && $stable(data_out) && !data_oe_n; endproperty
  a_setup: assert property (p_setup) else $error("addr or data moved");
  property p_read; take && cmd_op == OP_READ |=> ##1 (!ce_n && !oe_n)[*6] ##1 ce_n ##1 rsp_valid;
  endproperty
  a_read: assert property (p_read) else $error("read walk");
  property p_pulse; rsp_valid |=> !rsp_valid; endproperty
  a_pulse: assert property (p_pulse) else $error("response pulse");
  property p_lock; take && cmd_op == OP_LOCK |=> protected_mode; endproperty
  a_lock: assert property (p_lock) else $error("lock mode");
  property p_unlock; take && cmd_op == OP_UNLOCK |=> !protected_mode; endproperty
  a_unlock: assert property (p_unlock) else $error("unlock mode");
  property p_safe; !we_n |=> !reset_safe[*8]; endproperty
  a_safe: assert property (p_safe) else $error("safe too early");
  property p_quiet; cmd_ready |-> we_n && oe_n; endproperty
  a_quiet: assert property (p_quiet) else $error("strobe while ready");
endmodule // eeprom_host_assertions
`default_nettype wire

// ---- eeprom_host_params.svh ----
`ifndef EEPROM_HOST_PARAMS_SVH
`define EEPROM_HOST_PARAMS_SVH

`define CLK_MHZ          10
`define ADDR_W           17
`define DATA_W           8
`define PAGE_LSB         7
`define CNT_W            18
`define GUARD_W          17
`define SUB_W            4
`define SEQ_W            4

`define T_WP_NS          250
`define WP_CYC           ((`T_WP_NS * `CLK_MHZ + 999) / 1000)
`define T_ACC_NS         250
`define ACC_CYC          ((`T_ACC_NS * `CLK_MHZ + 999) / 1000)
`define SYNC_LAT         4
`define READ_CYC         (`ACC_CYC + `SYNC_LAT)
`define BYTE_CYC         (`WP_CYC + 3)
`define T_BLC_MAX_US     30
`define BLC_CYC          (`T_BLC_MAX_US * `CLK_MHZ)
`define GAP_LIMIT        (`BLC_CYC - `BYTE_CYC)
`define T_BL_US          100
`define BL_CYC           (`T_BL_US * `CLK_MHZ)
`define T_RP_US          100
`define RP_CYC           (`T_RP_US * `CLK_MHZ)
`define T_WC_MS          15
`define WC_CYC           (`T_WC_MS * 1000 * `CLK_MHZ)
`define T_RES_HOLD_MS    10
`define RES_HOLD_CYC     (`T_RES_HOLD_MS * 1000 * `CLK_MHZ)

`define SEQ_LOCK_FIRST   0
`define SEQ_LOCK_END     3
`define SEQ_UNLOCK_FIRST 3
`define SEQ_UNLOCK_END   9
`define CMD_ADDR_A       17'h05555
`define CMD_ADDR_B       17'h02AAA
`define CMD_DATA_1       8'hAA
`define CMD_DATA_2       8'h55
`define CMD_DATA_ERASE   8'h80
`define CMD_DATA_UNLOCK  8'h20
`define CMD_DATA_LOCK    8'hA0

`endif

// ---- eeprom_host_pkg.sv ----
package eeprom_host_pkg;

  typedef enum logic [1:0] {
    OP_READ   = 2'b00,
    OP_WRITE  = 2'b01,
    OP_LOCK   = 2'b10,
    OP_UNLOCK = 2'b11
  } op_e;

  typedef enum logic [3:0] {
    S_BOOT   = 4'b0000,
    S_IDLE   = 4'b0001,
    S_NEXT   = 4'b0010,
    S_SETUP  = 4'b0011,
    S_STROBE = 4'b0100,
    S_HOLD   = 4'b0101,
    S_GAP    = 4'b0110,
    S_WAITBL = 4'b0111,
    S_POLL   = 4'b1000,
    S_READ   = 4'b1001,
    S_DONE   = 4'b1010
  } state_e;

endpackage

// ---- pin_sync3.sv ----
`timescale 1ns/100ps
`default_nettype none
module pin_sync3 #(
  parameter int W = 9
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] q
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] next_q;

  // A bit changes only once the second and third stages agree
  always_comb begin
    for (int i = 0; i < W; i++) begin
      next_q[i] = (s2[i] == s3[i]) ? s3[i] : q[i];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      q  <= '0;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      q  <= next_q;
    end
  end

endmodule // pin_sync3
`default_nettype wire

// ---- tb_eeprom_host.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb_eeprom_host;
  import eeprom_host_pkg::*;
  logic        clk, srst, cmd_valid, cmd_ready, cmd_last, rsp_valid, rsp_timeout;
  logic        protected_mode, reset_safe, ce_n, oe_n, we_n, data_oe_n, ready_busy_in;
  logic        hold_off_n, slow;
  op_e         cmd_op;
  logic [16:0] cmd_addr, addr;
  logic [7:0]  cmd_data, rsp_data, data_out, data_in;
  int          err_count, compares;
  eeprom_host #(.WC_CYC(1500), .RES_HOLD_CYC(50)) eeprom_host_inst (.clk, .srst, .cmd_valid,
    .cmd_ready, .cmd_op, .cmd_addr, .cmd_data, .cmd_last, .rsp_valid, .rsp_data, .rsp_timeout,
    .protected_mode, .reset_safe, .ce_n, .oe_n, .we_n, .addr, .data_out, .data_oe_n, .data_in,
    .ready_busy_in, .hold_off_n);
  eeprom_dev_model eeprom_dev_model_inst (.clk, .ce_n, .oe_n, .we_n, .addr, .data_out,
    .data_oe_n, .hold_off_n, .slow, .data_in, .ready_busy_in);
  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmd(input op_e op, input logic [16:0] a, input logic [7:0] d, input logic l);
    int n;
    n = 0;
    @(negedge clk);
    cmd_valid = 1;
    cmd_op = op;
    cmd_addr = a;
    cmd_data = d;
    cmd_last = l;
    #1;
    while (cmd_ready !== 1'b1 && n < 4000) begin
      @(negedge clk);
      #1;
      n++;
    end
    chk({7'h00, cmd_ready}, 8'h01);
    @(negedge clk);
    cmd_valid = 0;
  endtask
  task automatic wait_rsp;
    int n;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 5000) begin
      @(negedge clk);
      n++;
    end
    chk({7'h00, rsp_valid}, 8'h01);
  endtask
  task automatic rd(input logic [16:0] a, input logic [7:0] exp);
    cmd(OP_READ, a, 8'h00, 1'b0);
    wait_rsp();
    chk(rsp_data, exp);
  endtask
  task automatic t_boot;
    int n;
    n = 0;
    chk({6'h00, hold_off_n, we_n}, 8'h01);
    srst = 0;
    while (cmd_ready !== 1'b1 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    chk({7'h00, n == 1000}, 8'h01);
  endtask
  task automatic t_page;
    cmd(OP_WRITE, 17'h00080, 8'h5A, 1'b0);
    cmd(OP_WRITE, 17'h000FF, 8'hC3, 1'b1);
    wait_rsp();
    chk({7'h00, rsp_timeout}, 8'h00);
    repeat (60) @(negedge clk);
    chk({7'h00, reset_safe}, 8'h01);
    rd(17'h00080, 8'h5A);
    rd(17'h000FF, 8'hC3);
    rd(17'h00081, 8'hFF);
  endtask
  task automatic t_protect;
    cmd(OP_LOCK, 17'h00000, 8'h00, 1'b0);
    chk({7'h00, protected_mode}, 8'h01);
    wait_rsp();
    cmd(OP_WRITE, 17'h00100, 8'h3C, 1'b1);
    wait_rsp();
    rd(17'h00100, 8'h3C);
    cmd(OP_UNLOCK, 17'h00000, 8'h00, 1'b0);
    chk({7'h00, protected_mode}, 8'h00);
    wait_rsp();
    rd(17'h05555, 8'hFF);
    rd(17'h02AAA, 8'hFF);
    cmd(OP_WRITE, 17'h00101, 8'h77, 1'b1);
    wait_rsp();
    rd(17'h00101, 8'h77);
  endtask
  task automatic t_slow;
    int n;
    n = 0;
    slow = 1;
    cmd(OP_WRITE, 17'h00200, 8'h11, 1'b1);
    wait_rsp();
    chk({7'h00, rsp_timeout}, 8'h01);
    slow = 0;
    while (ready_busy_in !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    rd(17'h00200, 8'h11);
  endtask
  // Lands after the model's idle window, inside its programming time
  task automatic t_abort;
    cmd(OP_WRITE, 17'h00300, 8'h99, 1'b1);
    repeat (1050) @(negedge clk);
    srst = 1;
    repeat (2) @(negedge clk);
    chk({7'h00, hold_off_n}, 8'h00);
    srst = 0;
    rd(17'h00300, 8'hFF);
  endtask
  task automatic close_out;
    $display("errors=%0d compares=%0d", err_count, compares);
    if (err_count == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    {srst, cmd_valid, cmd_last, slow} = 4'h8;
    cmd_op = OP_READ;
    cmd_addr = 17'h00000;
    cmd_data = 8'h00;
    err_count = 0;
    compares = 0;
    repeat (2) @(negedge clk);
    t_boot();
    t_page();
    t_protect();
    t_slow();
    t_abort();
    close_out();
  end
  initial begin
    repeat (40000) @(posedge clk);
    err_count++;
    close_out();
  end
endmodule // tb_eeprom_host
bind eeprom_host eeprom_host_assertions #(.WC_CYC(WC_CYC), .RES_HOLD_CYC(RES_HOLD_CYC))
  eeprom_host_assertions_inst (.clk, .srst, .cmd_valid, .cmd_ready, .cmd_op, .cmd_addr,
  .cmd_data, .cmd_last, .rsp_valid, .rsp_data, .rsp_timeout, .protected_mode, .reset_safe,
  .ce_n, .oe_n, .we_n, .addr, .data_out, .data_oe_n, .data_in, .ready_busy_in, .hold_off_n);
`default_nettype wire
